/* File: tmr8_pkg.sv */
package tmr8_pkg;

  localparam int          TMR8_W          = 8;
  localparam logic [7:0]  TMR8_BOTTOM     = 8'h00;
  localparam logic [7:0]  TMR8_MAX        = 8'hFF;
  localparam logic [7:0]  TMR8_CNT_RST    = 8'h00;
  localparam logic [7:0]  TMR8_ONE        = 8'h01;
  localparam logic [2:0]  TMR8_CS_OFF     = 3'h0;
  localparam logic [1:0]  TMR8_COM_NONE   = 2'h0;
  localparam logic [1:0]  TMR8_COM_TOGGLE = 2'h1;
  localparam logic [1:0]  TMR8_COM_CLEAR  = 2'h2;
  localparam logic [1:0]  TMR8_COM_SET    = 2'h3;

  // waveform mode codes
  localparam logic [2:0]  TMR8_WGM_NORMAL  = 3'h0;
  localparam logic [2:0]  TMR8_WGM_PC_MAX  = 3'h1;
  localparam logic [2:0]  TMR8_WGM_CTC     = 3'h2;
  localparam logic [2:0]  TMR8_WGM_FAST_MX = 3'h3;
  localparam logic [2:0]  TMR8_WGM_PC_OCA  = 3'h5;
  localparam logic [2:0]  TMR8_WGM_FAST_OA = 3'h7;

  // count direction state
  typedef enum logic [1:0] {
    TMR8_DIR_UP   = 2'b01,
    TMR8_DIR_DOWN = 2'b10
  } tmr8_dir_t;

  // control register a: action fields and low mode bits
  typedef struct packed {
    logic [1:0] action_a;
    logic [1:0] action_b;
    logic [1:0] rsvd;
    logic       waveform_mode_bit1;
    logic       waveform_mode_bit0;
  } tmr8_ctrl_a_t;

  // control register b: strobes, high mode bit, clock select
  typedef struct packed {
    logic       force_a;
    logic       force_b;
    logic [1:0] rsvd;
    logic       waveform_mode_bit2;
    logic [2:0] clock_select_field;
  } tmr8_ctrl_b_t;

  // flag / mask layout
  typedef struct packed {
    logic cmp_b;
    logic cmp_a;
    logic ovf;
  } tmr8_irq_t;

endpackage

/* File: tmr8_core.sv */
`timescale 1ns/10ps
`default_nettype none

module tmr8_core
  import tmr8_pkg::*;
(
  input  wire logic         mclk,          // io clock, 200 MHz
  input  wire logic         rstn,          // sync reset, active low
  input  wire logic         osc_pin_in,    // external oscillator pin
  input  wire logic         async_clock_select, // 1: tick from oscillator
  input  wire logic         prescale_tick, // io-clock tick from prescaler
  input  wire tmr8_ctrl_a_t ctrl_a_wdata,  // control_reg_a write data
  input  wire logic         ctrl_a_we,     // control_reg_a write
  input  wire tmr8_ctrl_b_t ctrl_b_wdata,  // control_reg_b write data
  input  wire logic         ctrl_b_we,     // control_reg_b write
  input  wire logic [7:0]   cnt_wdata,     // counter write data
  input  wire logic         cnt_we,        // counter write
  input  wire logic [7:0]   cmp_wdata,     // compare write data
  input  wire logic         cmp_a_we,      // compare_value_a write
  input  wire logic         cmp_b_we,      // compare_value_b write
  input  wire tmr8_irq_t    flag_w1c,      // flag write-one-to-clear
  input  wire tmr8_irq_t    irq_ack,       // interrupt serviced
  input  wire tmr8_irq_t    mask_wdata,    // mask_register write data
  input  wire logic         mask_we,       // mask_register write
  output logic [7:0]        counter_value, // counter readback
  output logic [7:0]        compare_value_a, // compare A readback
  output logic [7:0]        compare_value_b, // compare B readback
  output tmr8_irq_t         flag_register, // flags
  output tmr8_irq_t         mask_register, // masks
  output tmr8_irq_t         irq_req,       // masked requests
  output logic              compare_output_a, // output state A
  output logic              compare_output_b  // output state B
);

  logic [7:0]   cnt_reg;
  logic [7:0]   ocr_reg    [2];
  logic [7:0]   ocr_buf_reg[2];
  logic [1:0]   oc_reg;
  tmr8_ctrl_a_t ctrl_a_reg;
  logic [2:0]   cs_reg;
  tmr8_dir_t    dir_reg;
  tmr8_irq_t    flag_reg, mask_reg, irq_reg;
  logic         block_reg;
  logic         wgm2_reg;
  logic [7:0]   cmp_rd_reg [2];
  logic         osc_s1_reg, osc_s2_reg, osc_s3_reg;

  // mode decode, split field reassembled
  logic [2:0] wgm;
  logic       pwm, pcpwm, top_oca;
  logic [7:0] top;
  assign wgm     = {wgm2_reg,
                    ctrl_a_reg.waveform_mode_bit1, ctrl_a_reg.waveform_mode_bit0};
  // unused codes 4 and 6 fall through to pwm with top at max
  assign pwm     = (wgm != TMR8_WGM_NORMAL) && (wgm != TMR8_WGM_CTC);
  assign pcpwm   = (wgm == TMR8_WGM_PC_MAX) || (wgm == TMR8_WGM_PC_OCA);
  assign top_oca = (wgm == TMR8_WGM_CTC) || (wgm == TMR8_WGM_PC_OCA)
                   || (wgm == TMR8_WGM_FAST_OA);
  assign top     = top_oca ? ocr_reg[0] : TMR8_MAX;

  // bottom / max / top status
  logic at_bottom, at_max, at_top;
  assign at_bottom = (cnt_reg == TMR8_BOTTOM);
  assign at_max    = (cnt_reg == TMR8_MAX);
  assign at_top    = (cnt_reg == top);

  // oscillator pin synchroniser and edge detect
  // only the second flop feeds logic; the third just delays it for the edge
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
      osc_s3_reg <= 1'b0;
    end else begin
      osc_s1_reg <= osc_pin_in;
      osc_s2_reg <= osc_s1_reg;
      osc_s3_reg <= osc_s2_reg;
    end
  end

  // tick source select, stopped when clock select is zero
  logic tick;
  assign tick = (cs_reg != TMR8_CS_OFF) &&
                (async_clock_select ? (osc_s2_reg & ~osc_s3_reg) : prescale_tick);

  // control registers, reset with no source
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ctrl_a_reg <= '0;
      cs_reg     <= TMR8_CS_OFF;
      wgm2_reg   <= 1'b0;
    end else begin
      if (ctrl_a_we) ctrl_a_reg <= ctrl_a_wdata;
      if (ctrl_b_we) begin
        cs_reg   <= ctrl_b_wdata.clock_select_field;
        wgm2_reg <= ctrl_b_wdata.waveform_mode_bit2;
      end
    end
  end

  // counter next value
  logic [7:0] cnt_next;
  tmr8_dir_t  dir_next;
  always_comb begin
    cnt_next = cnt_reg;
    dir_next = dir_reg;
    if (tick) begin
      if (pcpwm) begin
        if (at_top) dir_next = TMR8_DIR_DOWN;
        else if (at_bottom) dir_next = TMR8_DIR_UP;
        cnt_next = (dir_next == TMR8_DIR_DOWN) ? cnt_reg - TMR8_ONE
                                               : cnt_reg + TMR8_ONE;
      end else if (wgm != TMR8_WGM_NORMAL && at_top) begin
        cnt_next = TMR8_BOTTOM;
        dir_next = TMR8_DIR_UP;
      end else begin
        cnt_next = cnt_reg + TMR8_ONE;
        dir_next = TMR8_DIR_UP;
      end
    end
    if (cnt_we) cnt_next = cnt_wdata;
  end

  // counter and direction registers
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cnt_reg <= TMR8_CNT_RST;
      dir_reg <= TMR8_DIR_UP;
    end else begin
      cnt_reg <= cnt_next;
      dir_reg <= dir_next;
    end
  end

  // match blocking: counter write blocks next tick
  // held while stopped, so a write before start still blocks the first tick
  always_ff @(posedge mclk) begin
    if (!rstn) block_reg <= 1'b0;
    else if (cnt_we) block_reg <= 1'b1;
    else if (tick) block_reg <= 1'b0;
  end

  // buffer update point: every pwm mode loads at top
  logic upd_pt;
  assign upd_pt = tick && at_top;

  // per-channel compare, buffer and waveform output
  logic [1:0] match;
  logic [1:0] force_hit;
  logic [1:0] cmp_we;
  logic [1:0] fset;
  assign cmp_we    = {cmp_b_we, cmp_a_we};
  assign force_hit = {ctrl_b_we & ctrl_b_wdata.force_b,
                      ctrl_b_we & ctrl_b_wdata.force_a} & {2{~pwm}};
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      logic [1:0] act;
      assign act = (ch == 0) ? ctrl_a_reg.action_a : ctrl_a_reg.action_b;
      assign match[ch] = tick && !block_reg && (cnt_reg == ocr_reg[ch]);

      // compare value and buffer
      always_ff @(posedge mclk) begin
        if (!rstn) begin
          ocr_reg[ch]     <= TMR8_CNT_RST;
          ocr_buf_reg[ch] <= TMR8_CNT_RST;
          cmp_rd_reg[ch]  <= TMR8_CNT_RST;
        end else begin
          if (cmp_we[ch]) ocr_buf_reg[ch] <= cmp_wdata;
          // readback flop; lags a mode change by one cycle
          if (cmp_we[ch]) cmp_rd_reg[ch] <= cmp_wdata;
          else cmp_rd_reg[ch] <= pwm ? ocr_buf_reg[ch] : ocr_reg[ch];
          if (!pwm && cmp_we[ch]) ocr_reg[ch] <= cmp_wdata;
          else if (pwm && upd_pt) ocr_reg[ch] <= ocr_buf_reg[ch];
        end
      end

      // output state, kept across mode changes
      always_ff @(posedge mclk) begin
        if (!rstn) oc_reg[ch] <= 1'b0;
        else if (!pwm && (match[ch] || force_hit[ch])) begin
          case (act)
            TMR8_COM_TOGGLE: oc_reg[ch] <= ~oc_reg[ch];
            TMR8_COM_CLEAR:  oc_reg[ch] <= 1'b0;
            TMR8_COM_SET:    oc_reg[ch] <= 1'b1;
            default:         oc_reg[ch] <= oc_reg[ch];
          endcase
        end else if (pwm && act[1]) begin
          if (match[ch] && pcpwm)
            oc_reg[ch] <= (dir_next == TMR8_DIR_UP) ? act[0] : ~act[0];
          else if (match[ch] && !(ch == 0 && top_oca))
            oc_reg[ch] <= act[0];
          else if (tick && at_top && !pcpwm)
            oc_reg[ch] <= ~act[0];                                     // ~act[0] at top, as the count wraps to bottom
        end else if (pwm && act == TMR8_COM_TOGGLE && ch == 0 && top_oca
                     && match[ch]) begin
          oc_reg[ch] <= ~oc_reg[ch];
        end
      end
      assign fset[ch] = match[ch];
    end
  endgenerate

  // overflow event per mode
  logic ovf_set;
  assign ovf_set = tick && (pcpwm ? (at_bottom && dir_reg == TMR8_DIR_DOWN)
                                  : (pwm ? at_top : at_max));

  // flags: set wins over clear
  tmr8_irq_t set_v, clr_v;
  assign set_v = '{cmp_b: fset[1], cmp_a: fset[0], ovf: ovf_set};
  assign clr_v = flag_w1c | irq_ack;
  always_ff @(posedge mclk) begin
    if (!rstn) flag_reg <= '0;
    else flag_reg <= set_v | (flag_reg & ~clr_v);
  end

  // mask and masked requests
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      mask_reg <= '0;
      irq_reg  <= '0;
    end else begin
      if (mask_we) mask_reg <= mask_wdata;
      irq_reg <= (set_v | (flag_reg & ~clr_v)) & (mask_we ? mask_wdata : mask_reg);
    end
  end

  // registered outputs
  assign counter_value    = cnt_reg;
  assign compare_value_a  = cmp_rd_reg[0];
  assign compare_value_b  = cmp_rd_reg[1];
  assign flag_register    = flag_reg;
  assign mask_register    = mask_reg;
  assign irq_req          = irq_reg;
  assign compare_output_a = oc_reg[0];
  assign compare_output_b = oc_reg[1];

  // assertions: counter
  a_stop_hold: assert property (@(posedge mclk) disable iff (!rstn)
    (cs_reg == TMR8_CS_OFF && !cnt_we) |=> $stable(cnt_reg))
    else $error("counter moved with no tick source");
  a_write_wins: assert property (@(posedge mclk) disable iff (!rstn)
    cnt_we |=> cnt_reg == $past(cnt_wdata))
    else $error("counter write lost");
  a_up_count: assert property (@(posedge mclk) disable iff (!rstn)
    (wgm == TMR8_WGM_NORMAL && tick && !at_max && !cnt_we)
      |=> cnt_reg == $past(cnt_reg) + TMR8_ONE)
    else $error("normal mode did not count up");
  a_normal_wrap: assert property (@(posedge mclk) disable iff (!rstn)
    (wgm == TMR8_WGM_NORMAL && tick && at_max && !cnt_we)
      |=> cnt_reg == TMR8_BOTTOM && flag_reg.ovf)
    else $error("normal mode wrap wrong");
  a_ctc_clear: assert property (@(posedge mclk) disable iff (!rstn)
    (wgm == TMR8_WGM_CTC && tick && cnt_reg == ocr_reg[0] && !cnt_we)
      |=> cnt_reg == TMR8_BOTTOM)
    else $error("clear on match missed");
  a_pc_turn: assert property (@(posedge mclk) disable iff (!rstn)
    (pcpwm && tick && at_top && !cnt_we) |=> dir_reg == TMR8_DIR_DOWN)
    else $error("phase correct count did not turn at top");
  a_pc_rise: assert property (@(posedge mclk) disable iff (!rstn)
    (pcpwm && tick && at_bottom && !at_top && !cnt_we) |=> dir_reg == TMR8_DIR_UP)
    else $error("phase correct count did not turn at bottom");

  // assertions: compare values and blocking
  a_direct_write: assert property (@(posedge mclk) disable iff (!rstn)
    (!pwm && cmp_b_we) |=> ocr_reg[1] == $past(cmp_wdata))
    else $error("direct compare write lost");
  a_buf_hold: assert property (@(posedge mclk) disable iff (!rstn)
    (pwm && !upd_pt) |=> $stable(ocr_reg[1]))
    else $error("buffered compare value moved off top");
  a_buf_load: assert property (@(posedge mclk) disable iff (!rstn)
    (pwm && upd_pt) |=> ocr_reg[0] == $past(ocr_buf_reg[0]))
    else $error("buffer not loaded at top");
  a_read_back: assert property (@(posedge mclk) disable iff (!rstn)
    cmp_a_we |=> compare_value_a == $past(cmp_wdata))
    else $error("compare readback wrong after write");
  a_block_set: assert property (@(posedge mclk) disable iff (!rstn)
    cnt_we |=> block_reg)
    else $error("counter write did not arm blocking");
  a_block_match: assert property (@(posedge mclk) disable iff (!rstn)
    (block_reg && !flag_reg.cmp_a && !flag_reg.cmp_b) |=> !flag_reg.cmp_a && !flag_reg.cmp_b)
    else $error("match not blocked after counter write");

  // assertions: flags, requests and outputs
  a_flag_set: assert property (@(posedge mclk) disable iff (!rstn)
    match[0] |=> flag_reg.cmp_a)
    else $error("compare flag a not set");
  a_flag_set_b: assert property (@(posedge mclk) disable iff (!rstn)
    match[1] |=> flag_reg.cmp_b)
    else $error("compare flag b not set");
  a_flag_clear: assert property (@(posedge mclk) disable iff (!rstn)
    (flag_w1c.cmp_a && !match[0]) |=> !flag_reg.cmp_a)
    else $error("compare flag a not cleared");
  a_irq_mask: assert property (@(posedge mclk) disable iff (!rstn)
    !mask_reg.ovf && !mask_we |=> !irq_reg.ovf)
    else $error("masked overflow request");
  a_irq_pass: assert property (@(posedge mclk) disable iff (!rstn)
    (mask_reg.ovf && !mask_we && flag_reg.ovf && !clr_v.ovf) |=> irq_reg.ovf)
    else $error("unmasked overflow request lost");
  a_force_noflag: assert property (@(posedge mclk) disable iff (!rstn)
    (force_hit[0] && !match[0] && !flag_reg.cmp_a) |=> !flag_reg.cmp_a)
    else $error("force strobe set flag");
  a_force_out: assert property (@(posedge mclk) disable iff (!rstn)
    (force_hit[0] && ctrl_a_reg.action_a == TMR8_COM_SET) |=> oc_reg[0])
    else $error("force strobe did not set output");
  a_keep_mode: assert property (@(posedge mclk) disable iff (!rstn)
    ((ctrl_a_we || ctrl_b_we) && !tick && !force_hit[0]) |=> $stable(oc_reg[0]))
    else $error("output changed on control write");
  a_no_action: assert property (@(posedge mclk) disable iff (!rstn)
    (ctrl_a_reg.action_b == TMR8_COM_NONE) |=> $stable(oc_reg[1]))
    else $error("output changed with no action");

  // covers for the main scenarios
  c_ovf: cover property (@(posedge mclk) disable iff (!rstn) ovf_set);
  c_match_a: cover property (@(posedge mclk) disable iff (!rstn) match[0]);
  c_force: cover property (@(posedge mclk) disable iff (!rstn) force_hit[0]);
  c_pwm_upd: cover property (@(posedge mclk) disable iff (!rstn) pwm && upd_pt);
  c_pc_turn: cover property (@(posedge mclk) disable iff (!rstn) pcpwm && tick && at_top);

endmodule

`default_nettype wire

/* File: tmr8_core_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module tmr8_core_bench;
  import tmr8_pkg::*;
  logic         mclk, rstn, osc_pin_in, async_clock_select, prescale_tick;
  logic         ctrl_a_we, ctrl_b_we, cnt_we, cmp_a_we, cmp_b_we, mask_we;
  logic         compare_output_a, compare_output_b;
  logic [7:0]   cnt_wdata, cmp_wdata, counter_value, compare_value_a, compare_value_b;
  tmr8_ctrl_a_t ctrl_a_wdata;
  tmr8_ctrl_b_t ctrl_b_wdata;
  tmr8_irq_t    flag_w1c, irq_ack, mask_wdata, flag_register, mask_register, irq_req;
  int           n_fail = 0;
  int           n_checks = 0;
  int           cyc = 0;

  tmr8_core DUT (.mclk(mclk), .rstn(rstn), .osc_pin_in(osc_pin_in),
    .async_clock_select(async_clock_select), .prescale_tick(prescale_tick),
    .ctrl_a_wdata(ctrl_a_wdata), .ctrl_a_we(ctrl_a_we), .ctrl_b_wdata(ctrl_b_wdata),
    .ctrl_b_we(ctrl_b_we), .cnt_wdata(cnt_wdata), .cnt_we(cnt_we), .cmp_wdata(cmp_wdata),
    .cmp_a_we(cmp_a_we), .cmp_b_we(cmp_b_we), .flag_w1c(flag_w1c), .irq_ack(irq_ack),
    .mask_wdata(mask_wdata), .mask_we(mask_we), .counter_value(counter_value),
    .compare_value_a(compare_value_a), .compare_value_b(compare_value_b),
    .flag_register(flag_register), .mask_register(mask_register), .irq_req(irq_req),
    .compare_output_a(compare_output_a), .compare_output_b(compare_output_b));

  // 200 MHz clock
  always #2.5 mclk = ~mclk;

  // end of run report
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end

  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // write both control registers in one cycle
  task automatic ctrl(input logic [1:0] aa, input logic [1:0] ab, input logic [2:0] wgm,
                      input logic [2:0] cs, input logic fa);
    @(posedge mclk);
    ctrl_a_wdata <= {aa, ab, 2'h0, wgm[1:0]};
    ctrl_b_wdata <= {fa, 1'b0, 2'h0, wgm[2], cs};
    ctrl_a_we    <= 1'b1;
    ctrl_b_we    <= 1'b1;
    @(posedge mclk);
    ctrl_a_we    <= 1'b0;
    ctrl_b_we    <= 1'b0;
    #1;
  endtask

  task automatic wcnt(input logic [7:0] v);
    @(posedge mclk);
    cnt_wdata <= v;
    cnt_we    <= 1'b1;
    @(posedge mclk);
    cnt_we    <= 1'b0;
    #1;
  endtask

  task automatic wcmp(input logic [7:0] v, input logic sel_b);
    @(posedge mclk);
    cmp_wdata <= v;
    cmp_a_we  <= ~sel_b;
    cmp_b_we  <= sel_b;
    @(posedge mclk);
    cmp_a_we  <= 1'b0;
    cmp_b_we  <= 1'b0;
    #1;
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge mclk);
      prescale_tick <= 1'b1;
      @(posedge mclk);
      prescale_tick <= 1'b0;
    end
    #1;
  endtask

  task automatic flags(input tmr8_irq_t w, input tmr8_irq_t a);
    @(posedge mclk);
    flag_w1c <= w;
    irq_ack  <= a;
    @(posedge mclk);
    flag_w1c <= 3'h0;
    irq_ack  <= 3'h0;
    #1;
  endtask

  task automatic wmask(input tmr8_irq_t m);
    @(posedge mclk);
    mask_wdata <= m;
    mask_we    <= 1'b1;
    @(posedge mclk);
    mask_we    <= 1'b0;
    #1;
  endtask

  // reset state, stopped counter, software write priority, wrap
  task automatic t_count;
    chk(counter_value, TMR8_CNT_RST);
    chk(compare_value_a, 8'h00);
    chk(compare_value_b, 8'h00);
    chk({2'h0, flag_register, mask_register}, 8'h00);
    chk({6'h00, compare_output_a, compare_output_b}, 8'h00);
    wcnt(8'h10);
    tick(3);
    chk(counter_value, 8'h10);
    ctrl(2'h0, 2'h0, TMR8_WGM_NORMAL, 3'h1, 1'b0);
    @(posedge mclk);
    cnt_wdata     <= 8'hFD;
    cnt_we        <= 1'b1;
    prescale_tick <= 1'b1;
    @(posedge mclk);
    cnt_we        <= 1'b0;
    prescale_tick <= 1'b0;
    #1;
    chk(counter_value, 8'hFD);
    tick(2);
    chk(counter_value, TMR8_MAX);
    tick(1);
    chk(counter_value, TMR8_BOTTOM);
    chk({5'h00, flag_register}, 8'h01);
    wmask(3'h1);
    chk({5'h00, irq_req}, 8'h01);
    wmask(3'h6);
    chk({5'h00, irq_req}, 8'h00);
    flags(3'h6, 3'h0);
    chk({5'h00, flag_register}, 8'h01);
    flags(3'h1, 3'h0);
    chk({5'h00, flag_register}, 8'h00);
  endtask

  // match flags, output actions, blocking, force strobe
  task automatic t_match;
    ctrl(TMR8_COM_TOGGLE, TMR8_COM_NONE, TMR8_WGM_NORMAL, 3'h1, 1'b0);
    wcmp(8'h50, 1'b0);
    wcmp(8'h50, 1'b1);
    wcnt(8'h4E);
    tick(2);
    chk({5'h00, flag_register}, 8'h00);
    tick(1);
    chk({5'h00, flag_register}, 8'h06);
    chk({6'h00, compare_output_a, compare_output_b}, 8'h02);
    flags(3'h0, 3'h2);
    chk({5'h00, flag_register}, 8'h04);
    flags(3'h7, 3'h0);
    ctrl(TMR8_COM_TOGGLE, TMR8_COM_NONE, TMR8_WGM_NORMAL, TMR8_CS_OFF, 1'b0);
    wcnt(8'h50);
    ctrl(TMR8_COM_TOGGLE, TMR8_COM_NONE, TMR8_WGM_NORMAL, 3'h1, 1'b0);
    tick(1);
    chk({5'h00, flag_register}, 8'h00);
    chk({7'h00, compare_output_a}, 8'h01);
    ctrl(TMR8_COM_CLEAR, TMR8_COM_NONE, TMR8_WGM_NORMAL, TMR8_CS_OFF, 1'b0);
    chk({7'h00, compare_output_a}, 8'h01);
    ctrl(TMR8_COM_CLEAR, TMR8_COM_NONE, TMR8_WGM_NORMAL, TMR8_CS_OFF, 1'b1);
    chk({7'h00, compare_output_a}, 8'h00);
    chk({5'h00, flag_register}, 8'h00);
    chk(counter_value, 8'h51);
    ctrl(TMR8_COM_SET, TMR8_COM_NONE, TMR8_WGM_FAST_MX, TMR8_CS_OFF, 1'b0);
    chk({7'h00, compare_output_a}, 8'h00);
    ctrl(TMR8_COM_SET, TMR8_COM_NONE, TMR8_WGM_FAST_MX, TMR8_CS_OFF, 1'b1);
    chk({7'h00, compare_output_a}, 8'h00);
  endtask

  // clear on match, double buffering, down count, oscillator source
  task automatic t_modes;
    ctrl(2'h0, 2'h0, TMR8_WGM_CTC, 3'h1, 1'b0);
    wcmp(8'h03, 1'b0);
    wcnt(8'h00);
    tick(3);
    chk(counter_value, 8'h03);
    tick(1);
    chk(counter_value, 8'h00);
    ctrl(2'h0, 2'h0, TMR8_WGM_NORMAL, TMR8_CS_OFF, 1'b0);
    wcmp(8'h0A, 1'b1);
    chk(compare_value_b, 8'h0A);
    ctrl(2'h0, 2'h0, TMR8_WGM_FAST_MX, 3'h1, 1'b0);
    wcmp(8'h14, 1'b1);
    chk(compare_value_b, 8'h14);
    wcnt(8'h08);
    flags(3'h7, 3'h0);
    tick(3);
    chk({7'h00, flag_register.cmp_b}, 8'h01);
    wcnt(8'hFE);
    tick(22);
    flags(3'h7, 3'h0);
    tick(1);
    chk({7'h00, flag_register.cmp_b}, 8'h01);
    ctrl(2'h0, 2'h0, TMR8_WGM_FAST_OA, 3'h1, 1'b0);
    wcnt(8'h00);
    tick(4);
    chk(counter_value, 8'h00);
    ctrl(2'h0, 2'h0, TMR8_WGM_PC_MAX, 3'h1, 1'b0);
    wcnt(8'hFE);
    tick(2);
    chk(counter_value, 8'hFE);
    ctrl(2'h0, 2'h0, TMR8_WGM_NORMAL, 3'h1, 1'b0);
    @(posedge mclk);
    async_clock_select <= 1'b1;
    wcnt(8'h20);
    tick(3);
    chk(counter_value, 8'h20);
    repeat (3) begin
      repeat (4) @(posedge mclk);
      osc_pin_in <= 1'b1;
      repeat (4) @(posedge mclk);
      osc_pin_in <= 1'b0;
    end
    repeat (6) @(posedge mclk);
    #1;
    chk(counter_value, 8'h23);
  endtask

  initial begin
    {mclk, rstn, osc_pin_in, async_clock_select, prescale_tick} = 5'h00;
    {ctrl_a_we, ctrl_b_we, cnt_we, cmp_a_we, cmp_b_we, mask_we} = 6'h00;
    {ctrl_a_wdata, ctrl_b_wdata, cnt_wdata, cmp_wdata} = 32'h0;
    {flag_w1c, irq_ack, mask_wdata} = 9'h000;
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    #1;
    t_count();
    t_match();
    t_modes();
    stop_test();
  end
endmodule
`default_nettype wire
